//--- rtl/bfb_pkg.sv
// package of the baseband frame buffer: register offsets, widths, reset values
// assumes a byte-wide register port decoded by the surrounding control interface
package bfb_pkg;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned LEN_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REG_AW = 4;
  localparam logic [10:0] MAX_OCTETS = 11'h7ff;
  // register offsets of the local register port
  localparam logic [3:0] OFF_PHY_STATUS = 4'h0;
  localparam logic [3:0] OFF_LEVEL_LOW = 4'h1;
  localparam logic [3:0] OFF_LEVEL_HIGH = 4'h2;
  localparam logic [3:0] OFF_RX_LEN_LOW = 4'h3;
  localparam logic [3:0] OFF_RX_LEN_HIGH = 4'h4;
  localparam logic [3:0] OFF_TX_LEN_LOW = 4'h5;
  localparam logic [3:0] OFF_TX_LEN_HIGH = 4'h6;
  localparam logic [3:0] OFF_THR_LOW = 4'h7;
  localparam logic [3:0] OFF_THR_HIGH = 4'h8;
  localparam logic [3:0] OFF_CHECKSUM_CTRL = 4'h9;
  // field positions and widths
  localparam int unsigned TX_UNDERRUN_FLAG_BIT = 0;
  localparam int unsigned ACS_EN_BIT = 0;
  localparam int unsigned ACS_TYPE_BIT = 1;
  localparam int unsigned HIGH_W = 3;
  // reset values and checksum octet counts
  localparam logic [7:0] THR_LOW_RST = 8'hff;
  localparam logic [2:0] THR_HIGH_RST = 3'h7;
  localparam logic [10:0] PTR_MINUS_ONE = 11'h7ff;
  localparam logic [2:0] CRC16_OCTETS = 3'h2;
  localparam logic [2:0] CRC32_OCTETS = 3'h4;
  // radio commands
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_TX = 3'h1;
  localparam logic [2:0] CMD_RX = 3'h2;
  localparam logic [2:0] CMD_TX_REPEAT = 3'h3;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_PREAMBLE = 2'b01,
    TX_PAYLOAD = 2'b10,
    TX_DONE = 2'b11
  } bfb_tx_state_t;
endpackage

//--- rtl/bfb_mem.sv
// one octet-wide buffer memory with one write and one registered read port
// assumes both ports run on the transceiver's internal clock
module bfb_mem #(
  parameter int unsigned AW = 11,
  parameter int unsigned DW = 8
) (
  input wire logic sys_clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule

//--- rtl/bfb_top.sv
// transmit and receive payload buffers of one baseband core, with length,
// underrun, level gauge and level-threshold logic
// assumes the host side and the core side both run on sys_clk_i; the
// link clock from the core arrives from outside and is synchronised here

// Function
// - tx buffer holds 2047 octets, lowest address sent first
// - rx buffer stores up to 2047 octets at ascending addresses
// - rx octets are stored only after frame start interrupt
// - rx length loads with frame start irq; zero length suppresses irq
// - frame end irq only after all octets are stored
// - tx buffer holds payload only; headers made elsewhere
// - first tx read only after preamble end
// - tx frame end irq after all octets read and sent
// - tx length is high and low length registers, checksum included
// - auto checksum replaces last 2 or 4 octets per type
// - underrun set when host address below core read address
// - after underrun stale octets are still sent
// - tx length low write clears underrun, host address to minus one
// - transmit start command clears underrun
// - checksum after underrun covers data actually read
// - repeat transmission keeps buffer, length and underrun flag
// - rx gauge counts stored octets, cleared by receive command
// - tx gauge counts read octets, cleared during preamble
// - gauge is 11 bits over low and high registers
// - threshold irq when stored count exceeds 11-bit threshold
// - new threshold low takes effect when high is written
// - threshold resets to all ones
module bfb_top #(
  parameter int unsigned AW = bfb_pkg::ADDR_W
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [bfb_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [bfb_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [bfb_pkg::DATA_W-1:0] reg_rdata_o,
  // host buffer port
  input wire logic host_tx_wr_i,
  input wire logic [bfb_pkg::ADDR_W-1:0] host_tx_addr_i,
  input wire logic [bfb_pkg::DATA_W-1:0] host_tx_data_i,
  input wire logic [bfb_pkg::ADDR_W-1:0] host_rx_addr_i,
  output logic [bfb_pkg::DATA_W-1:0] host_rx_data_o,
  input wire logic [2:0] radio_command_i,
  // core side, from the link clock domain
  input wire logic link_clk_i,
  input wire logic preamble_done_i,
  input wire logic phy_header_valid_i,
  input wire logic [bfb_pkg::LEN_W-1:0] phy_rx_length_i,
  input wire logic rx_octet_valid_i,
  input wire logic [bfb_pkg::DATA_W-1:0] rx_octet_i,
  input wire logic rx_frame_done_i,
  input wire logic [bfb_pkg::DATA_W-1:0] checksum_octet_i,
  output logic [bfb_pkg::DATA_W-1:0] tx_octet_o,
  output logic tx_octet_valid_o,
  output logic tx_checksum_slot_o,
  output logic rx_frame_start_irq_o,
  output logic rx_frame_end_irq_o,
  output logic tx_frame_end_irq_o,
  output logic level_threshold_irq_o
);
  import bfb_pkg::*;

  typedef struct packed {
    logic [4:0] lclk;
    logic [1:0] pre;
    logic [1:0] hdr;
    logic [1:0] rxv;
    logic [1:0] rxd;
    logic [10:0] rx_len_sync;
    logic [7:0] rx_byte_sync;
    logic [10:0] rx_len_meta;
    logic [7:0] rx_byte_meta;
    logic [7:0] csum_meta;
    logic [7:0] csum_sync;
    bfb_tx_state_t tx_st;
    logic [10:0] tx_len;
    logic [10:0] tx_ptr;
    logic [10:0] host_ptr;
    logic [10:0] core_ptr;
    logic underrun;
    logic rx_active;
    logic [10:0] rx_len;
    logic [10:0] level;
    logic [7:0] thr_low_pend;
    logic [10:0] thr;
    logic thr_fired;
    logic acs_en;
    logic acs_type;
    logic [7:0] rdata;
    logic [7:0] tx_octet;
    logic tx_valid;
    logic tx_csum;
    logic rd_pend;
    logic rx_frame_start_irq;
    logic rx_frame_end_irq;
    logic tx_frame_end_irq;
    logic level_threshold_irq;
    logic [2:0] lvl_high_snap;
  } bfb_state_t;

  bfb_state_t s_q, s_d;
  logic [7:0] tx_rd_data;
  logic rx_wr;
  logic link_rise;

  function automatic logic [7:0] high_byte(input logic [10:0] v);
    high_byte = {5'h00, v[10:8]};
  endfunction

  bfb_mem #(.AW(AW), .DW(DATA_W)) u_tx_mem (
    .sys_clk_i(sys_clk_i),
    .wr_en_i(host_tx_wr_i),
    .wr_addr_i(host_tx_addr_i),
    .wr_data_i(host_tx_data_i),
    .rd_addr_i(s_q.tx_ptr),
    .rd_data_o(tx_rd_data)
  );

  bfb_mem #(.AW(AW), .DW(DATA_W)) u_rx_mem (
    .sys_clk_i(sys_clk_i),
    .wr_en_i(rx_wr),
    .wr_addr_i(s_q.level),
    .wr_data_i(s_q.rx_byte_sync),
    .rd_addr_i(host_rx_addr_i),
    .rd_data_o(host_rx_data_o)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  assign link_rise = s_q.lclk[3] & ~s_q.lclk[4];
  assign rx_wr = s_q.rx_active & link_rise & s_q.rxv[1]
                 & (s_q.level < s_q.rx_len);

  always_comb begin
    s_d = s_q;
    s_d.lclk = {s_q.lclk[3:0], link_clk_i};
    s_d.lclk[4] = s_q.lclk[3];
    s_d.pre = {s_q.pre[0], preamble_done_i};
    s_d.hdr = {s_q.hdr[0], phy_header_valid_i};
    s_d.rxv = {s_q.rxv[0], rx_octet_valid_i};
    s_d.rxd = {s_q.rxd[0], rx_frame_done_i};
    // core data words pass two stages, qualified by synced strobes
    s_d.rx_len_meta = phy_rx_length_i;
    s_d.rx_len_sync = s_q.rx_len_meta;
    s_d.rx_byte_meta = rx_octet_i;
    s_d.rx_byte_sync = s_q.rx_byte_meta;
    s_d.csum_meta = checksum_octet_i;
    s_d.csum_sync = s_q.csum_meta;
    s_d.rx_frame_start_irq = 1'b0;
    s_d.rx_frame_end_irq = 1'b0;
    s_d.tx_frame_end_irq = 1'b0;
    s_d.level_threshold_irq = 1'b0;
    s_d.tx_valid = 1'b0;
    s_d.rd_pend = 1'b0;

    // register writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFF_TX_LEN_LOW: begin
          s_d.tx_len[7:0] = reg_wdata_i;
          s_d.underrun = 1'b0;
          s_d.host_ptr = PTR_MINUS_ONE;
        end
        OFF_TX_LEN_HIGH: s_d.tx_len[10:8] = reg_wdata_i[HIGH_W-1:0];
        OFF_THR_LOW: s_d.thr_low_pend = reg_wdata_i;
        OFF_THR_HIGH: s_d.thr = {reg_wdata_i[HIGH_W-1:0], s_q.thr_low_pend};
        OFF_CHECKSUM_CTRL: begin
          s_d.acs_en = reg_wdata_i[ACS_EN_BIT];
          s_d.acs_type = reg_wdata_i[ACS_TYPE_BIT];
        end
        default: ;
      endcase
    end
    if (host_tx_wr_i) begin
      s_d.host_ptr = host_tx_addr_i;
    end

    // register reads; high gauge byte taken with low for burst access
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFF_PHY_STATUS: s_d.rdata = {7'h00, s_q.underrun};
        OFF_LEVEL_LOW: begin
          s_d.rdata = s_q.level[7:0];
          s_d.lvl_high_snap = s_q.level[10:8];
        end
        OFF_LEVEL_HIGH: s_d.rdata = {5'h00, s_q.lvl_high_snap};
        OFF_RX_LEN_LOW: s_d.rdata = s_q.rx_len[7:0];
        OFF_RX_LEN_HIGH: s_d.rdata = high_byte(s_q.rx_len);
        OFF_TX_LEN_LOW: s_d.rdata = s_q.tx_len[7:0];
        OFF_TX_LEN_HIGH: s_d.rdata = high_byte(s_q.tx_len);
        OFF_THR_LOW: s_d.rdata = s_q.thr_low_pend;
        OFF_THR_HIGH: s_d.rdata = high_byte(s_q.thr);
        OFF_CHECKSUM_CTRL: s_d.rdata = {6'h00, s_q.acs_type, s_q.acs_en};
        default: s_d.rdata = 8'h00;
      endcase
    end

    // receive path
    if (radio_command_i == CMD_RX) begin
      s_d.level = '0;
      s_d.rx_active = 1'b0;
      s_d.thr_fired = 1'b0;
    end else begin
      if (s_q.hdr[1] & ~s_q.rx_active & link_rise) begin
        s_d.rx_len = s_q.rx_len_sync;
        s_d.rx_active = (s_q.rx_len_sync != '0);
        s_d.rx_frame_start_irq = (s_q.rx_len_sync != '0);
        s_d.level = '0;
        s_d.thr_fired = 1'b0;
      end
      if (rx_wr) begin
        s_d.level = s_q.level + 11'h001;
        if (!s_q.thr_fired && (s_q.level + 11'h001) > s_q.thr) begin
          s_d.level_threshold_irq = 1'b1;
          s_d.thr_fired = 1'b1;
        end
      end
      // frame end only once every octet is in the buffer
      if (s_q.rx_active & s_q.rxd[1] & (s_q.level == s_q.rx_len) & ~rx_wr) begin
        s_d.rx_frame_end_irq = 1'b1;
        s_d.rx_active = 1'b0;
      end
    end

    // transmit path
    unique case (s_q.tx_st)
      TX_IDLE: begin
        if (radio_command_i == CMD_TX || radio_command_i == CMD_TX_REPEAT) begin
          s_d.tx_st = TX_PREAMBLE;
          s_d.tx_ptr = '0;
          s_d.core_ptr = '0;
          if (radio_command_i == CMD_TX) begin
            s_d.underrun = 1'b0;
          end
          // repeat keeps underrun, buffer and lengths untouched
        end
      end
      TX_PREAMBLE: begin
        s_d.level = '0;
        if (s_q.pre[1]) begin
          s_d.tx_st = TX_PAYLOAD;
        end
      end
      TX_PAYLOAD: begin
        if (link_rise) begin
          // payload only from buffer; headers come from the phy
          s_d.rd_pend = 1'b1;
          s_d.core_ptr = s_q.tx_ptr;
        end
        if (s_q.rd_pend) begin
          s_d.tx_octet = tx_rd_data;
          s_d.tx_valid = 1'b1;
          s_d.tx_csum = s_q.acs_en & ((s_q.tx_len - s_q.tx_ptr) <=
                        {8'h00, s_q.acs_type ? CRC16_OCTETS : CRC32_OCTETS});
          if (s_q.acs_en && s_d.tx_csum) begin
            s_d.tx_octet = s_q.csum_sync;
          end
          s_d.level = s_q.level + 11'h001;
          if (s_q.tx_ptr + 11'h001 >= s_q.tx_len) begin
            s_d.tx_st = TX_DONE;
          end else begin
            s_d.tx_ptr = s_q.tx_ptr + 11'h001;
          end
        end
      end
      TX_DONE: begin
        s_d.tx_frame_end_irq = 1'b1;
        s_d.tx_st = TX_IDLE;
      end
    endcase

    // underrun: host address below core read address, set wins
    if (s_q.tx_st == TX_PAYLOAD && s_q.host_ptr != PTR_MINUS_ONE
        && s_q.host_ptr < s_q.core_ptr) begin
      s_d.underrun = 1'b1;
    end else if (s_q.tx_st == TX_PAYLOAD && s_q.host_ptr == PTR_MINUS_ONE
                 && s_q.rd_pend) begin
      s_d.underrun = 1'b1;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.tx_st <= TX_IDLE;
      s_q.host_ptr <= PTR_MINUS_ONE;
      s_q.thr_low_pend <= THR_LOW_RST;
      s_q.thr <= {THR_HIGH_RST, THR_LOW_RST};
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    reg_rdata_o = s_q.rdata;
    tx_octet_o = s_q.tx_octet;
    tx_octet_valid_o = s_q.tx_valid;
    tx_checksum_slot_o = s_q.tx_csum;
    rx_frame_start_irq_o = s_q.rx_frame_start_irq;
    rx_frame_end_irq_o = s_q.rx_frame_end_irq;
    tx_frame_end_irq_o = s_q.tx_frame_end_irq;
    level_threshold_irq_o = s_q.level_threshold_irq;
  end
endmodule

//--- dv/bfb_asserts.sv
// port checker of the frame buffer
// assumes a bind onto bfb_top
module bfb_asserts import bfb_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_rd_i,
  input wire logic [bfb_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [bfb_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic preamble_done_i,
  input wire logic [bfb_pkg::LEN_W-1:0] phy_rx_length_i,
  input wire logic rx_frame_done_i,
  input wire logic tx_octet_valid_o,
  input wire logic rx_frame_start_irq_o,
  input wire logic rx_frame_end_irq_o,
  input wire logic tx_frame_end_irq_o,
  input wire logic level_threshold_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // assertions
  // ****
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_start_len_nonzero: assert property (rx_frame_start_irq_o |-> $past(phy_rx_length_i) != 0)
    else $error("frame start on zero length");
  chk_start_before_end: assert property (rx_frame_start_irq_o |=> !rx_frame_end_irq_o [*8])
    else $error("frame end right after start");
  chk_end_after_done: assert property (rx_frame_end_irq_o |-> rx_frame_done_i)
    else $error("frame end before core done");
  chk_read_after_preamble: assert property (tx_octet_valid_o |-> preamble_done_i)
    else $error("tx read during preamble");
  chk_no_read_after_end: assert property (tx_frame_end_irq_o |=> !tx_octet_valid_o [*8])
    else $error("tx read after frame end");
  chk_thr_once: assert property (level_threshold_irq_o |=> !level_threshold_irq_o [*8])
    else $error("threshold irq repeated");
  chk_level_high_width: assert property (reg_rd_i && reg_addr_i == OFF_LEVEL_HIGH |=>
    reg_rdata_o[7:3] == 5'h00) else $error("level high wider than 3 bits");
  chk_txlen_high_width: assert property (reg_rd_i && reg_addr_i == OFF_TX_LEN_HIGH |=>
    reg_rdata_o[7:3] == 5'h00) else $error("tx length high wider than 3 bits");
  cover property (tx_frame_end_irq_o);
  cover property (rx_frame_end_irq_o);
  cover property (level_threshold_irq_o);
endmodule

//--- dv/bfb_core_model.sv
// behavioural baseband core on the core side of the buffer
// assumes the bench calls its tasks by hierarchical name
module bfb_core_model (
  output logic link_clk_o,
  output logic preamble_done_o,
  output logic hdr_valid_o,
  output logic [10:0] rx_len_o,
  output logic oct_valid_o,
  output logic [7:0] oct_o,
  output logic done_o,
  output logic [7:0] fcs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_clk_o = 0;
    preamble_done_o = 0;
    hdr_valid_o = 0;
    rx_len_o = 0;
    oct_valid_o = 0;
    oct_o = 0;
    done_o = 0;
    fcs_o = 8'h5a;
  end
  // ****
  // frames; link clock stands still between them
  // ****
  task automatic tick(input int n);
    repeat (n) begin
      #80 link_clk_o = 1;
      #80 link_clk_o = 0;
    end
  endtask
  task automatic tx_frame(input int n);
    preamble_done_o = 0;
    tick(4);
    preamble_done_o = 1;
    tick(n + 8);
    preamble_done_o = 0;
  endtask
  task automatic rx_frame(input logic [10:0] len, input logic [7:0] base);
    hdr_valid_o = 1;
    rx_len_o = len;
    tick(1);
    hdr_valid_o = 0;
    for (int i = 0; i < len; i++) begin
      oct_valid_o = 1;
      oct_o = base + 8'(i);
      tick(1);
    end
    oct_valid_o = 0;
    oct_o = ~oct_o;
    done_o = 1;
    tick(3);
    done_o = 0;
  endtask
endmodule

//--- dv/tb_baseband_frame_buffer.sv
// self-checking bench of the frame buffer
// assumes bfb_top, bfb_core_model and bfb_asserts are compiled first
module tb_baseband_frame_buffer import bfb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, host_tx_wr_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, host_tx_data_i, host_rx_data_o, rx_octet_i;
  logic [10:0] host_tx_addr_i, host_rx_addr_i, phy_rx_length_i;
  logic [2:0] radio_command_i;
  logic link_clk_i, preamble_done_i, phy_header_valid_i, rx_octet_valid_i, rx_frame_done_i;
  logic [7:0] checksum_octet_i, tx_octet_o;
  logic tx_octet_valid_o, tx_checksum_slot_o, rx_frame_start_irq_o, rx_frame_end_irq_o;
  logic tx_frame_end_irq_o, level_threshold_irq_o;
  int n_mismatch, checked, n_sfi, n_efi, n_txe, n_thr, cyc;
  logic [7:0] txq[$];
  logic slq[$];
  bfb_top #(.AW(ADDR_W)) DUT (.*);
  bfb_core_model core (.link_clk_o(link_clk_i), .preamble_done_o(preamble_done_i),
    .hdr_valid_o(phy_header_valid_i), .rx_len_o(phy_rx_length_i),
    .oct_valid_o(rx_octet_valid_i), .oct_o(rx_octet_i), .done_o(rx_frame_done_i),
    .fcs_o(checksum_octet_i));
  initial begin
    sys_clk_i = 0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // outputs are looked at mid-cycle, where they have settled
  always @(negedge sys_clk_i) begin
    if (tx_octet_valid_o) txq.push_back(tx_octet_o);
    if (tx_octet_valid_o) slq.push_back(tx_checksum_slot_o);
    n_sfi = n_sfi + rx_frame_start_irq_o;
    n_efi = n_efi + rx_frame_end_irq_o;
    n_txe = n_txe + tx_frame_end_irq_o;
    n_thr = n_thr + level_threshold_irq_o;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ****
  // bus tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge sys_clk_i);
    reg_wr_i = 0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(negedge sys_clk_i);
    reg_rd_i = 1;
    reg_addr_i = a;
    @(negedge sys_clk_i);
    reg_rd_i = 0;
    chk(reg_rdata_o, exp);
  endtask
  task automatic bw(input logic [10:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    host_tx_wr_i = 1;
    host_tx_addr_i = a;
    host_tx_data_i = d;
    @(negedge sys_clk_i);
    host_tx_wr_i = 0;
  endtask
  task automatic hrd(input logic [10:0] a, input logic [7:0] exp);
    @(negedge sys_clk_i);
    host_rx_addr_i = a;
    @(negedge sys_clk_i);
    chk(host_rx_data_o, exp);
  endtask
  task automatic cm(input logic [2:0] c);
    @(negedge sys_clk_i);
    radio_command_i = c;
    @(negedge sys_clk_i);
    radio_command_i = CMD_NONE;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rd_chk(OFF_THR_LOW, 8'hff);
    rd_chk(OFF_THR_HIGH, 8'h07);
    rd_chk(OFF_PHY_STATUS, 8'h00);
    rd_chk(OFF_TX_LEN_HIGH, 8'h00);
    rd_chk(4'hf, 8'h00);
  endtask
  task automatic t_tx;
    wr(OFF_TX_LEN_HIGH, 8'h00);
    wr(OFF_TX_LEN_LOW, 8'h06);
    for (int i = 0; i < 6; i++) bw(11'(i), 8'h10 + 8'(i));
    for (int t = 0; t < 3; t++) begin
      wr(OFF_CHECKSUM_CTRL, t == 0 ? 8'h00 : t == 1 ? 8'h03 : 8'h01);
      txq.delete();
      slq.delete();
      n_txe = 0;
      cm(CMD_TX);
      core.tx_frame(6);
      chk(8'(txq.size()), 8'h06);
      chk(8'(n_txe), 8'h01);
      for (int i = 0; i < 6; i++) chk(txq[i], i >= 6 - 2 * t ? 8'h5a : 8'h10 + 8'(i));
      for (int i = 0; i < 6; i++) chk(8'(slq[i]), 8'(i >= 6 - 2 * t));
    end
    rd_chk(OFF_LEVEL_LOW, 8'h06);
    rd_chk(OFF_PHY_STATUS, 8'h00);
  endtask
  task automatic t_under;
    wr(OFF_CHECKSUM_CTRL, 8'h00);
    wr(OFF_TX_LEN_LOW, 8'h06);
    txq.delete();
    cm(CMD_TX);
    core.tx_frame(6);
    for (int i = 0; i < 6; i++) chk(txq[i], 8'h10 + 8'(i));
    rd_chk(OFF_PHY_STATUS, 8'h01);
    cm(CMD_TX_REPEAT);
    core.tx_frame(6);
    rd_chk(OFF_PHY_STATUS, 8'h01);
    cm(CMD_TX);
    rd_chk(OFF_PHY_STATUS, 8'h00);
    core.tx_frame(6);
    wr(OFF_TX_LEN_LOW, 8'h06);
    rd_chk(OFF_PHY_STATUS, 8'h00);
  endtask
  task automatic t_rx;
    wr(OFF_THR_LOW, 8'h02);
    n_sfi = 0;
    n_efi = 0;
    n_thr = 0;
    cm(CMD_RX);
    core.rx_frame(11'h004, 8'h40);
    chk(8'(n_thr), 8'h00);
    chk(8'(n_sfi), 8'h01);
    chk(8'(n_efi), 8'h01);
    for (int i = 0; i < 4; i++) hrd(11'(i), 8'h40 + 8'(i));
    rd_chk(OFF_RX_LEN_LOW, 8'h04);
    rd_chk(OFF_RX_LEN_HIGH, 8'h00);
    rd_chk(OFF_LEVEL_LOW, 8'h04);
    rd_chk(OFF_LEVEL_HIGH, 8'h00);
    wr(OFF_THR_HIGH, 8'h00);
    cm(CMD_RX);
    rd_chk(OFF_LEVEL_LOW, 8'h00);
    core.rx_frame(11'h004, 8'h50);
    chk(8'(n_thr), 8'h01);
    cm(CMD_RX);
    core.rx_frame(11'h000, 8'h60);
    chk(8'(n_sfi), 8'h02);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    sys_rst_i = 1;
    reg_wr_i = 0;
    reg_rd_i = 0;
    reg_addr_i = 0;
    reg_wdata_i = 0;
    host_tx_wr_i = 0;
    host_tx_addr_i = 0;
    host_tx_data_i = 0;
    host_rx_addr_i = 0;
    radio_command_i = CMD_NONE;
    repeat (4) @(negedge sys_clk_i);
    sys_rst_i = 0;
    t_reset();
    t_tx();
    t_under();
    t_rx();
    end_of_test();
  end
endmodule
bind bfb_top bfb_asserts chk (.*);
